// *** hw/pld_pkg.sv ***
// Shared constants and types for the lock detect and phase detector block
package pld_pkg;

  // Feedback divider ratio limits
  localparam int          RATIO_W        = 17;
  localparam logic [16:0] FRAC_RATIO_MIN = 17'h00024;
  localparam logic [16:0] FRAC_RATIO_MAX = 17'h0ffff;
  localparam logic [16:0] INT_RATIO_MIN  = 17'h00020;
  localparam logic [16:0] INT_RATIO_MAX  = 17'h1001f;

  // Clock and analog one-shot timing
  localparam int CLK_PERIOD_PS      = 50000;
  localparam int ANALOG_HALF_WIN_NS = 10;
  localparam int ANALOG_HALF_RAW    =
    (ANALOG_HALF_WIN_NS * 1000) / CLK_PERIOD_PS;
  localparam int ANALOG_HALF_CYC    =
    (ANALOG_HALF_RAW < 1) ? 1 : ANALOG_HALF_RAW;

  // Window and counter widths
  localparam int WIN_W = 16;
  localparam int CFG_W = 4;
  localparam int DUR_W = 8;
  localparam int CNT_W = 16;

  // Window constants
  localparam logic [WIN_W-1:0] WIN_ZERO      = 16'h0000;
  localparam logic [WIN_W-1:0] WIN_SAT       = 16'hffff;
  localparam logic [WIN_W-1:0] WIN_ONE       = 16'h0001;
  localparam logic [WIN_W-1:0] RING_BASE_CYC = 16'h0001;
  localparam logic [WIN_W-1:0] ANALOG_WIDTH  = WIN_W'(2 * ANALOG_HALF_CYC);

  // Window limits in clock cycles around the reference edge
  typedef struct packed {
    logic [WIN_W-1:0] early;
    logic [WIN_W-1:0] late;
  } pld_win_lim_t;

  // Charge pump requests
  typedef struct packed {
    logic up;
    logic dn;
  } pld_pump_t;

  typedef enum logic [1:0] {
    PLD_PFD_IDLE = 2'b00,
    PLD_PFD_UP   = 2'b01,
    PLD_PFD_DN   = 2'b10
  } pld_pfd_state_t;

endpackage : pld_pkg

// *** hw/pld_win_calc.sv ***
// Lock window limit generator
`timescale 1ns/1ps
module pld_win_calc
  import pld_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  // Window controls
  input  wire logic             ring_sel_in,
  input  wire logic [CFG_W-1:0] ring_cfg_in,
  input  wire logic [DUR_W-1:0] duration_in,
  input  wire logic             asym_en_in,
  input  wire logic             asym_delay_in,
  // Window limits
  output pld_win_lim_t          lim_out
);

  logic [WIN_W-1:0] width;
  pld_win_lim_t     nxt_lim;
  pld_win_lim_t     lim_ff;

  always_comb
  begin
    if (ring_sel_in)
      width = WIN_W'(duration_in) * (WIN_W'(ring_cfg_in) + RING_BASE_CYC);
    else
      width = ANALOG_WIDTH;
    if (asym_en_in && asym_delay_in)
    begin
      nxt_lim.early = WIN_ZERO;
      nxt_lim.late  = width;
    end
    else if (asym_en_in)
    begin
      nxt_lim.early = width;
      nxt_lim.late  = WIN_ZERO;
    end
    else
    begin
      nxt_lim.early = width >> 1;
      nxt_lim.late  = width >> 1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      lim_ff <= '0;
    else
      lim_ff <= nxt_lim;
  end

  assign lim_out = lim_ff;

  AST_ANALOG_WIN: assert property (@(posedge clk_in) disable iff (srst_in)
    !ring_sel_in && !asym_en_in |=> lim_ff.early == WIN_ONE &&
      lim_ff.late == WIN_ONE)
    else $error("analog window is not one cycle each side");

  AST_ASYM_DELAY: assert property (@(posedge clk_in) disable iff (srst_in)
    asym_en_in && asym_delay_in |=> lim_ff.early == WIN_ZERO)
    else $error("delayed window still accepts early edges");

  AST_ASYM_ADV: assert property (@(posedge clk_in) disable iff (srst_in)
    asym_en_in && !asym_delay_in |=> lim_ff.late == WIN_ZERO)
    else $error("advanced window still accepts late edges");

endmodule : pld_win_calc

// *** hw/pld_phase_det.sv ***
// Phase frequency detector with polarity swap and output masking
`timescale 1ns/1ps
module pld_phase_det
  import pld_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic srst_in,
  // Divided edges
  input  wire logic ref_edge_in,
  input  wire logic vco_edge_in,
  // Controls
  input  wire logic invert_in,
  input  wire logic up_en_in,
  input  wire logic dn_en_in,
  // Pump requests
  output pld_pump_t pump_out,
  output logic      tristate_out
);

  pld_pfd_state_t state_ff;
  pld_pfd_state_t nxt_state;
  pld_pump_t      raw;
  pld_pump_t      pump_ff;
  logic           tristate_ff;

  // Leading edge opens a request; the lagging edge closes it
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      PLD_PFD_IDLE:
        if (ref_edge_in && !vco_edge_in)
          nxt_state = PLD_PFD_UP;
        else if (vco_edge_in && !ref_edge_in)
          nxt_state = PLD_PFD_DN;
      PLD_PFD_UP:
        if (vco_edge_in)
          nxt_state = PLD_PFD_IDLE;
      PLD_PFD_DN:
        if (ref_edge_in)
          nxt_state = PLD_PFD_IDLE;
      default:
        nxt_state = PLD_PFD_IDLE;
    endcase
  end

  always_comb
  begin
    raw.up = (nxt_state == PLD_PFD_UP);
    raw.dn = (nxt_state == PLD_PFD_DN);
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      state_ff <= PLD_PFD_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      pump_ff <= '0;
    else
    begin
      pump_ff.up <= (invert_in ? raw.dn : raw.up) && up_en_in;
      pump_ff.dn <= (invert_in ? raw.up : raw.dn) && dn_en_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      tristate_ff <= 1'b0;
    else
      tristate_ff <= !up_en_in && !dn_en_in;
  end

  assign pump_out     = pump_ff;
  assign tristate_out = tristate_ff;

  AST_PFD_LEAD_UP: assert property (@(posedge clk_in) disable iff (srst_in)
    state_ff == PLD_PFD_IDLE && ref_edge_in && !vco_edge_in && !invert_in &&
      up_en_in |=> pump_ff.up && !pump_ff.dn)
    else $error("leading reference edge gave no up request");

  AST_PFD_INVERT: assert property (@(posedge clk_in) disable iff (srst_in)
    state_ff == PLD_PFD_IDLE && ref_edge_in && !vco_edge_in && invert_in &&
      dn_en_in |=> pump_ff.dn && !pump_ff.up)
    else $error("inverted polarity did not swap requests");

  AST_MASK_UP: assert property (@(posedge clk_in) disable iff (srst_in)
    !up_en_in |=> !pump_ff.up)
    else $error("masked up request reached the pump");

  AST_MASK_DN: assert property (@(posedge clk_in) disable iff (srst_in)
    !dn_en_in |=> !pump_ff.dn)
    else $error("masked down request reached the pump");

  AST_TRISTATE: assert property (@(posedge clk_in) disable iff (srst_in)
    !up_en_in && !dn_en_in |=> tristate_ff && !pump_ff.up && !pump_ff.dn)
    else $error("pump not idle with both requests masked");

endmodule : pld_phase_det

// *** hw/pld_lock_detect.sv ***
// Phase detector control and lock detector top level
`timescale 1ns/1ps
module pld_lock_detect
  import pld_pkg::*;
#(
  parameter int COUNT_W = CNT_W
)
(
  // Clock and reset
  input  wire logic               CLOCK_IN,
  input  wire logic               SRST_IN,
  // Divided edges, one-cycle pulses
  input  wire logic               REF_EDGE_IN,
  input  wire logic               VCO_EDGE_IN,
  // Divider configuration
  input  wire logic               FRAC_MODE_IN,
  input  wire logic [RATIO_W-1:0] DIVIDE_RATIO_IN,
  // Phase detector controls
  input  wire logic               PHASE_INVERT_IN,
  input  wire logic               UP_REQUEST_ENABLE_IN,
  input  wire logic               DOWN_REQUEST_ENABLE_IN,
  // Lock detector controls
  input  wire logic               LOCK_DETECT_ENABLE_IN,
  input  wire logic               RING_ONESHOT_SELECT_IN,
  input  wire logic [CFG_W-1:0]   RING_OSC_CFG_IN,
  input  wire logic [DUR_W-1:0]   ONESHOT_DURATION_IN,
  input  wire logic [COUNT_W-1:0] LOCK_COUNT_MAX_IN,
  input  wire logic               WIN_ASYM_ENABLE_IN,
  input  wire logic               WIN_ASYM_DELAY_SEL_IN,
  // Shared pin controls
  input  wire logic               LOCK_OUTPUT_ENABLE_IN,
  input  wire logic               SERIAL_READ_ACTIVE_IN,
  input  wire logic               SERIAL_DATA_IN,
  // Charge pump requests
  output logic                    PUMP_UP_OUT,
  output logic                    PUMP_DOWN_OUT,
  output logic                    PUMP_TRISTATE_OUT,
  // Status
  output logic                    RATIO_VALID_OUT,
  output logic                    LOCK_STATUS_OUT,
  // Shared lock or serial out pin
  output logic                    LOCK_OR_SERIAL_OUT_PIN_OUT,
  output logic                    LOCK_OR_SERIAL_OUT_PIN_OE_N_OUT
);

  if (COUNT_W < 2 || COUNT_W > 31)
  begin : g_bad_count_w
    $error("COUNT_W must lie between 2 and 31");
  end

  localparam logic [COUNT_W-1:0] CNT_ZERO = '0;
  localparam logic [COUNT_W-1:0] CNT_ONE  = COUNT_W'(1);

  // Saturating increment for the cycle distance counters
  function automatic logic [WIN_W-1:0] sat_inc(input logic [WIN_W-1:0] v);
    sat_inc = (v == WIN_SAT) ? WIN_SAT : v + WIN_ONE;
  endfunction : sat_inc

  // Divider ratio legality for the selected mode
  function automatic logic ratio_ok(input logic             frac,
                                    input logic [RATIO_W-1:0] r);
    if (frac)
      ratio_ok = (r >= FRAC_RATIO_MIN) && (r <= FRAC_RATIO_MAX);
    else
      ratio_ok = (r >= INT_RATIO_MIN) && (r <= INT_RATIO_MAX);
  endfunction : ratio_ok

  pld_pump_t        pump;
  logic             tristate;
  pld_win_lim_t     lim;

  logic             ratio_ok_ff;
  logic [WIN_W-1:0] since_ref_ff;
  logic [WIN_W-1:0] nxt_since_ref;
  logic             pend_ff;
  logic             nxt_pend;
  logic [WIN_W-1:0] wait_ff;
  logic [WIN_W-1:0] nxt_wait;
  logic             hit;
  logic             miss;
  logic             late_hit;
  logic             early_hit;
  logic             early_miss;
  logic [COUNT_W-1:0] count_ff;
  logic [COUNT_W-1:0] nxt_count;
  logic [COUNT_W-1:0] count_max;
  logic             lock_ff;
  logic             nxt_lock;
  logic             pin_ff;
  logic             pin_oe_n_ff;

  pld_phase_det u_phase_det (
    .clk_in       (CLOCK_IN),
    .srst_in      (SRST_IN),
    .ref_edge_in  (REF_EDGE_IN),
    .vco_edge_in  (VCO_EDGE_IN),
    .invert_in    (PHASE_INVERT_IN),
    .up_en_in     (UP_REQUEST_ENABLE_IN),
    .dn_en_in     (DOWN_REQUEST_ENABLE_IN),
    .pump_out     (pump),
    .tristate_out (tristate)
  );

  pld_win_calc u_win_calc (
    .clk_in        (CLOCK_IN),
    .srst_in       (SRST_IN),
    .ring_sel_in   (RING_ONESHOT_SELECT_IN),
    .ring_cfg_in   (RING_OSC_CFG_IN),
    .duration_in   (ONESHOT_DURATION_IN),
    .asym_en_in    (WIN_ASYM_ENABLE_IN),
    .asym_delay_in (WIN_ASYM_DELAY_SEL_IN),
    .lim_out       (lim)
  );

  // Divider ratio check
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
      ratio_ok_ff <= 1'b0;
    else
      ratio_ok_ff <= ratio_ok(FRAC_MODE_IN, DIVIDE_RATIO_IN);
  end

  // Cycles since the last reference edge; saturated means none seen
  always_comb
  begin
    if (REF_EDGE_IN)
      nxt_since_ref = WIN_ONE;
    else
      nxt_since_ref = sat_inc(since_ref_ff);
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN || !LOCK_DETECT_ENABLE_IN)
      since_ref_ff <= WIN_SAT;
    else
      since_ref_ff <= nxt_since_ref;
  end

  // Window judgement of each feedback edge
  always_comb
  begin
    late_hit   = VCO_EDGE_IN &&
                 (REF_EDGE_IN || since_ref_ff <= lim.late);
    early_hit  = pend_ff && REF_EDGE_IN && wait_ff <= lim.early;
    early_miss = pend_ff && !early_hit &&
                 (VCO_EDGE_IN || wait_ff >= lim.early);
    nxt_pend   = pend_ff && !early_hit && !early_miss;
    nxt_wait   = sat_inc(wait_ff);
    miss       = early_miss;
    if (VCO_EDGE_IN && !late_hit)
    begin
      if (lim.early == WIN_ZERO)
        miss = 1'b1;
      else
      begin
        nxt_pend = 1'b1;
        nxt_wait = WIN_ONE;
      end
    end
    hit = late_hit || early_hit;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN || !LOCK_DETECT_ENABLE_IN)
      pend_ff <= 1'b0;
    else
      pend_ff <= nxt_pend;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
      wait_ff <= WIN_ZERO;
    else
      wait_ff <= nxt_wait;
  end

  // Consecutive hit run and lock flag
  always_comb
  begin
    count_max = (LOCK_COUNT_MAX_IN == CNT_ZERO) ? CNT_ONE : LOCK_COUNT_MAX_IN;
    nxt_count = count_ff;
    nxt_lock  = lock_ff;
    if (miss)
    begin
      nxt_count = hit ? CNT_ONE : CNT_ZERO;
      nxt_lock  = 1'b0;
    end
    else if (hit)
    begin
      if (count_ff < count_max)
        nxt_count = count_ff + CNT_ONE;
      // Compare below the limit so a full-width run cannot wrap to zero
      nxt_lock = lock_ff || (count_ff >= count_max - CNT_ONE);
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN || !LOCK_DETECT_ENABLE_IN)
      count_ff <= CNT_ZERO;
    else
      count_ff <= nxt_count;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN || !LOCK_DETECT_ENABLE_IN)
      lock_ff <= 1'b0;
    else
      lock_ff <= nxt_lock;
  end

  // Shared pin: serial data wins during a read
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
      pin_ff <= 1'b0;
    else if (SERIAL_READ_ACTIVE_IN)
      pin_ff <= SERIAL_DATA_IN;
    else if (LOCK_OUTPUT_ENABLE_IN)
      pin_ff <= lock_ff;
    else
      pin_ff <= 1'b0;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
      pin_oe_n_ff <= 1'b1;
    else
      pin_oe_n_ff <= !(SERIAL_READ_ACTIVE_IN || LOCK_OUTPUT_ENABLE_IN);
  end

  assign PUMP_UP_OUT                     = pump.up;
  assign PUMP_DOWN_OUT                   = pump.dn;
  assign PUMP_TRISTATE_OUT               = tristate;
  assign RATIO_VALID_OUT                 = ratio_ok_ff;
  assign LOCK_STATUS_OUT                 = lock_ff;
  assign LOCK_OR_SERIAL_OUT_PIN_OUT      = pin_ff;
  assign LOCK_OR_SERIAL_OUT_PIN_OE_N_OUT = pin_oe_n_ff;

  sequence s_enabled_miss;
    LOCK_DETECT_ENABLE_IN && miss;
  endsequence

  sequence s_lock_rise;
    !lock_ff ##1 lock_ff;
  endsequence

  sequence s_run_step;
    LOCK_DETECT_ENABLE_IN && hit && !miss && (count_ff < count_max);
  endsequence

  AST_RATIO_FRAC: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    FRAC_MODE_IN && (DIVIDE_RATIO_IN < FRAC_RATIO_MIN) |=> !RATIO_VALID_OUT)
    else $error("fractional ratio below minimum reported valid");

  AST_RATIO_INT: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    !FRAC_MODE_IN && (DIVIDE_RATIO_IN == INT_RATIO_MAX) |=> RATIO_VALID_OUT)
    else $error("largest integer ratio reported invalid");

  AST_LD_DISABLED: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    !LOCK_DETECT_ENABLE_IN |=> !LOCK_STATUS_OUT && count_ff == CNT_ZERO)
    else $error("disabled detector shows lock or a run");

  AST_MISS_DROPS: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    s_enabled_miss |=> !LOCK_STATUS_OUT)
    else $error("out of window edge did not drop lock");

  AST_LOCK_RUN: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    s_lock_rise |-> $past(count_ff) + CNT_ONE >= $past(count_max))
    else $error("lock rose before the run completed");

  AST_PIN_READ: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    SERIAL_READ_ACTIVE_IN |=> LOCK_OR_SERIAL_OUT_PIN_OUT ==
      $past(SERIAL_DATA_IN) && !LOCK_OR_SERIAL_OUT_PIN_OE_N_OUT)
    else $error("pin did not carry serial data during read");

  AST_PIN_LOCK: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    LOCK_OUTPUT_ENABLE_IN && !SERIAL_READ_ACTIVE_IN |=>
      LOCK_OR_SERIAL_OUT_PIN_OUT == $past(lock_ff))
    else $error("pin did not show lock flag");

  AST_SAME_CYCLE_HIT: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    LOCK_DETECT_ENABLE_IN && VCO_EDGE_IN && REF_EDGE_IN && !pend_ff |-> !miss)
    else $error("coincident edges judged outside window");

  AST_RUN_COUNT: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    s_run_step |=> count_ff == $past(count_ff) + CNT_ONE)
    else $error("in window edge did not advance the run");

  AST_LOCK_HOLD: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    LOCK_DETECT_ENABLE_IN && lock_ff && !miss |=> lock_ff)
    else $error("lock flag fell without an out of window edge");

  AST_MISS_RESTART: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    s_enabled_miss |=> count_ff <= CNT_ONE)
    else $error("run did not restart after a miss");

  AST_LD_OFF_CLEAR: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    !LOCK_DETECT_ENABLE_IN |=> !pend_ff && since_ref_ff == WIN_SAT)
    else $error("disabled detector kept window state");

  AST_PIN_IDLE: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    !LOCK_OUTPUT_ENABLE_IN && !SERIAL_READ_ACTIVE_IN |=>
      LOCK_OR_SERIAL_OUT_PIN_OE_N_OUT && !LOCK_OR_SERIAL_OUT_PIN_OUT)
    else $error("released pin still driven");

  AST_DELAY_MISS: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    LOCK_DETECT_ENABLE_IN && VCO_EDGE_IN && !REF_EDGE_IN &&
      lim.early == WIN_ZERO && since_ref_ff > lim.late |-> miss)
    else $error("edge outside delayed window not judged a miss");

  AST_ADV_HIT: assert property (@(posedge CLOCK_IN)
    disable iff (SRST_IN)
    LOCK_DETECT_ENABLE_IN && pend_ff && REF_EDGE_IN &&
      wait_ff <= lim.early |-> hit)
    else $error("reference inside advanced window not judged a hit");

endmodule : pld_lock_detect

// *** tb/pld_edge_src.sv ***
// Model of the reference and feedback divider edge sources
`timescale 1ns/1ps
module pld_edge_src
(
  // Clock and command
  input  wire logic              clk_in,
  input  wire logic              fire_in,
  input  wire logic signed [7:0] lag_in,
  // Divided edges, one-cycle pulses
  output logic                   ref_edge_out,
  output logic                   vco_edge_out
);
  logic [7:0] ref_left_ff = 8'h00;
  logic [7:0] vco_left_ff = 8'h00;
  logic [1:0] armed_ff    = 2'b00;

  // Positive lag delays the feedback edge, negative lag the reference
  always @(posedge clk_in)
  begin
    ref_edge_out <= 1'b0;
    vco_edge_out <= 1'b0;
    if (fire_in)
    begin
      armed_ff    <= 2'b11;
      ref_left_ff <= (lag_in < 0) ? 8'(-lag_in) : 8'h00;
      vco_left_ff <= (lag_in > 0) ? 8'(lag_in) : 8'h00;
    end
    else
    begin
      if (armed_ff[0])
      begin
        if (ref_left_ff == 8'h00)
        begin
          ref_edge_out <= 1'b1;
          armed_ff[0]  <= 1'b0;
        end
        else
          ref_left_ff <= ref_left_ff - 8'h01;
      end
      if (armed_ff[1])
      begin
        if (vco_left_ff == 8'h00)
        begin
          vco_edge_out <= 1'b1;
          armed_ff[1]  <= 1'b0;
        end
        else
          vco_left_ff <= vco_left_ff - 8'h01;
      end
    end
  end
endmodule : pld_edge_src

// *** tb/test_pld_lock_detect.sv ***
// Self-checking bench for the phase detector and lock detector
`timescale 1ns/1ps
module test_pld_lock_detect
  import pld_pkg::*;
;
  logic               clk = 1'b0;
  logic               srst, ref_e, vco_e, fire, frac, inv, up_en, dn_en;
  logic               lkd_en, ring_sel, asym_en, asym_dly, lock_oe, ser_rd;
  logic               ser_d, p_up, p_dn, p_tri, ratio_ok, lock, pin, oe_n;
  logic signed [7:0]  lag;
  logic [RATIO_W-1:0] ratio;
  logic [CFG_W-1:0]   ring_cfg;
  logic [DUR_W-1:0]   dur;
  logic [15:0]        cmax;
  int                 ups, dns, bad_count, tests_run;
  localparam logic [16:0] RAT [8] = '{17'h00023, 17'h00024, 17'h0ffff,
    17'h10000, 17'h0001f, 17'h00020, 17'h1001f, 17'h10020};
  localparam int RUN [8] = '{4, 0, 1, -1, 2, 0, 1, 0};
  localparam int WIN [11] = '{3, 4, -3, -4, 2, -1, 2, 3, -2, 1, 0};

  always #25 clk = ~clk;

  pld_edge_src i_pld_edge_src (.clk_in(clk), .fire_in(fire), .lag_in(lag),
    .ref_edge_out(ref_e), .vco_edge_out(vco_e));

  pld_lock_detect i_pld_lock_detect (.CLOCK_IN(clk), .SRST_IN(srst),
    .REF_EDGE_IN(ref_e), .VCO_EDGE_IN(vco_e), .FRAC_MODE_IN(frac),
    .DIVIDE_RATIO_IN(ratio), .PHASE_INVERT_IN(inv),
    .UP_REQUEST_ENABLE_IN(up_en), .DOWN_REQUEST_ENABLE_IN(dn_en),
    .LOCK_DETECT_ENABLE_IN(lkd_en), .RING_ONESHOT_SELECT_IN(ring_sel),
    .RING_OSC_CFG_IN(ring_cfg), .ONESHOT_DURATION_IN(dur),
    .LOCK_COUNT_MAX_IN(cmax), .WIN_ASYM_ENABLE_IN(asym_en),
    .WIN_ASYM_DELAY_SEL_IN(asym_dly), .LOCK_OUTPUT_ENABLE_IN(lock_oe),
    .SERIAL_READ_ACTIVE_IN(ser_rd), .SERIAL_DATA_IN(ser_d),
    .PUMP_UP_OUT(p_up), .PUMP_DOWN_OUT(p_dn), .PUMP_TRISTATE_OUT(p_tri),
    .RATIO_VALID_OUT(ratio_ok), .LOCK_STATUS_OUT(lock),
    .LOCK_OR_SERIAL_OUT_PIN_OUT(pin),
    .LOCK_OR_SERIAL_OUT_PIN_OE_N_OUT(oe_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time,
               what, seen, exp);
    end
  endtask : check

  // Inputs change 5 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : tick

  // One reference and feedback edge pair, counting pump request cycles
  task automatic pair(input int l);
    lag  = 8'(l);
    fire = 1'b1;
    tick(1);
    fire = 1'b0;
    ups  = 0;
    dns  = 0;
    repeat (14)
    begin
      tick(1);
      ups += int'(p_up);
      dns += int'(p_dn);
    end
  endtask : pair

  task automatic end_sim;
    $display("checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  initial
  begin
    #(4000 * 50);
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    {fire, lag, frac, ratio, inv, ring_sel, asym_en, asym_dly} = '0;
    {lock_oe, ser_rd, ser_d, bad_count, tests_run} = '0;
    {srst, up_en, dn_en, lkd_en} = 4'hf;
    ring_cfg = 4'h1;
    dur      = 8'h03;
    cmax     = 16'h0001;
    tick(16);
    check({p_up, p_dn, lock, oe_n}, 4'h1, "reset outputs");
    srst = 1'b0;
    tick(2);
    for (int i = 0; i < 8; i++)
    begin
      frac  = (i < 4);
      ratio = RAT[i];
      tick(2);
      check(ratio_ok, (i % 4 == 1 || i % 4 == 2), "ratio range");
    end
    $display("test ratio done");
    for (int i = 0; i < 18; i++)
    begin
      inv = (i >= 9);
      pair(i % 9 - 4);
      check(inv ? dns : ups, (i % 9 > 4) ? i % 9 - 4 : 0, "up");
      check(inv ? ups : dns, (i % 9 < 4) ? 4 - i % 9 : 0, "dn");
    end
    inv   = 1'b0;
    up_en = 1'b0;
    pair(3);
    check(ups, 0, "up masked");
    pair(-3);
    check(dns, 3, "dn kept");
    {up_en, dn_en} = 2'b10;
    pair(-3);
    check(dns, 0, "dn masked");
    pair(3);
    check(ups, 3, "up kept");
    up_en = 1'b0;
    pair(0);
    check(p_tri, 1'b1, "tristate");
    check(lock, 1'b1, "lock runs while tristated");
    {up_en, dn_en} = 2'b11;
    tick(3);
    check(p_tri, 1'b0, "tristate off");
    $display("test pfd done");
    cmax = 16'h0003;
    for (int i = 0; i < 8; i++)
    begin
      pair(RUN[i]);
      check(lock, (i == 3 || i == 7), "lock run");
    end
    lkd_en = 1'b0;
    tick(2);
    check(lock, 1'b0, "disabled");
    for (int i = 0; i < 3; i++)
      pair(0);
    check(lock, 1'b0, "no count while disabled");
    lkd_en = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      pair(0);
      check(lock, (i == 2), "run after enable");
    end
    $display("test lock done");
    cmax = 16'h0001;
    for (int i = 0; i < 11; i++)
    begin
      ring_sel = (i < 4);
      asym_en  = (i >= 4);
      asym_dly = (i >= 4 && i < 8);
      pair(WIN[i]);
      check(lock, (i % 2 == 0), "window");
    end
    $display("test window done");
    lock_oe = 1'b1;
    tick(2);
    check({pin, oe_n}, 2'b10, "pin shows lock");
    ser_rd = 1'b1;
    tick(2);
    check({pin, oe_n}, 2'b00, "pin serial 0");
    ser_d = 1'b1;
    tick(2);
    check({pin, oe_n}, 2'b10, "pin serial 1");
    {ser_rd, ser_d} = 2'b00;
    tick(2);
    check({pin, oe_n}, 2'b10, "pin back to lock");
    pair(4);
    check({pin, oe_n}, 2'b00, "pin shows unlock");
    lock_oe = 1'b0;
    tick(2);
    check({pin, oe_n}, 2'b01, "pin released");
    $display("test pin done");
    end_sim();
  end
endmodule : test_pld_lock_detect
